// File: hdl/udf_pkg.sv
// package: register offsets, field layout, reset values and carrier types
package udf_pkg;

  // =====================================================
  // register map
  localparam logic [7:0] UDF_UCAST_OFS  = 8'h83;
  localparam logic [7:0] UDF_MCAST_OFS  = 8'h84;
  localparam logic [7:0] UDF_VLAN_OFS   = 8'h85;

  // =====================================================
  // field layout
  localparam int UDF_EN_BIT    = 5;
  localparam int UDF_MAP_W     = 5;
  localparam int UDF_RSVD_MAP  = 3;
  localparam int UDF_NUM_PORTS = 4;

  // =====================================================
  // reset values
  localparam logic [1:0] UDF_UCAST_RSVD_RST = 2'h2;
  localparam logic [1:0] UDF_MCAST_RSVD_RST = 2'h1;
  localparam logic [1:0] UDF_VLAN_RSVD_RST  = 2'h0;
  localparam logic       UDF_EN_RST         = 1'h0;
  localparam logic [4:0] UDF_MAP_RST        = 5'h00;
  localparam logic [4:0] UDF_MAP_BCAST      = 5'h1F;

  // =====================================================
  // carrier types
  typedef struct packed {
    logic       enable;
    logic [4:0] portMap;
  } udf_ctrl_t;

  typedef struct packed {
    logic [3:0] ports;
    logic       drop;
  } udf_fwd_t;

  typedef enum logic [1:0] {
    UDF_KIND_UCAST = 2'h0,
    UDF_KIND_MCAST = 2'h1,
    UDF_KIND_VLAN  = 2'h3
  } udf_kind_t;

endpackage

// File: hdl/udf_forward_ctrl.sv
// unknown-destination forwarding control registers and port selection
// =====================================================
// Overview of operation
// - unicast forward enable at bit 5 resets to 0; enables use of port map.
// - enabled unicast with map 00000 drops unresolved unicast frames.
// - unicast map bits 0 to 2 each select one port; 00001 is port one only.
// - unicast map all ones broadcasts to every switch port.
// - map bit 3 is reserved; only meaningful inside the all-ones value.
// - multicast forward enable resets to 0; IP multicast is not covered.
// - multicast map resets to zero, which drops; else bits 0 to 2 select one port each.
// - multicast map all ones broadcasts to every switch port.
// - VLAN forward enable resets to 0; enables use of its port map.
// - VLAN map resets to zero, which discards unknown-VLAN frames.
// - VLAN map 00111 sends to ports one to three; all ones broadcasts.
`timescale 1ns/1ps

module udf_forward_ctrl
  import udf_pkg::*;
#(
  parameter int NumPorts = UDF_NUM_PORTS
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // management register access
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWrData,
  output logic      [7:0]          regRdData,
  output logic                     regRdValid,
  // lookup request from forwarding engine
  input  wire logic                lookupValid,
  input  wire udf_kind_t           lookupKind,
  input  wire logic                lookupIpMcast,
  // forwarding decision
  output logic                     fwdValid,
  output logic                     fwdDrop,
  output logic      [NumPorts-1:0] fwdPorts,
  output logic                     fwdBypass
);

  // =====================================================
  // decode
  function automatic logic [NumPorts-1:0] map_to_ports(input udf_ctrl_t c);
    logic [NumPorts-1:0] p;
    p = '0;
    if (c.portMap == UDF_MAP_BCAST) begin
      p = '1;
    end else begin
      for (int i = 0; i < NumPorts; i++) begin
        // bit 3 carries no port outside broadcast
        if (i < UDF_MAP_W && i != UDF_RSVD_MAP) begin
          p[i] = c.portMap[i];
        end
      end
    end
    return p;
  endfunction

  udf_ctrl_t ucast_q, ucast_d;
  udf_ctrl_t mcast_q, mcast_d;
  udf_ctrl_t vlan_q, vlan_d;

  wire logic hitUcast = regAddr == UDF_UCAST_OFS;
  wire logic hitMcast = regAddr == UDF_MCAST_OFS;
  wire logic hitVlan  = regAddr == UDF_VLAN_OFS;
  wire udf_ctrl_t wrCtrl = '{enable: regWrData[UDF_EN_BIT], portMap: regWrData[UDF_MAP_W-1:0]};

  // reserved bits 7:6 never stored, so writes cannot reach them
  assign ucast_d = (regWrEn && hitUcast) ? wrCtrl : ucast_q;
  assign mcast_d = (regWrEn && hitMcast) ? wrCtrl : mcast_q;
  assign vlan_d  = (regWrEn && hitVlan)  ? wrCtrl : vlan_q;

  wire logic [7:0] rdMux =
    hitUcast ? {UDF_UCAST_RSVD_RST, ucast_q.enable, ucast_q.portMap} :
    hitMcast ? {UDF_MCAST_RSVD_RST, mcast_q.enable, mcast_q.portMap} :
    hitVlan  ? {UDF_VLAN_RSVD_RST,  vlan_q.enable,  vlan_q.portMap}  :
    8'h00;

  // =====================================================
  // forwarding selection
  wire udf_ctrl_t selCtrl =
    (lookupKind == UDF_KIND_UCAST) ? ucast_q :
    (lookupKind == UDF_KIND_MCAST) ? mcast_q : vlan_q;
  // ip multicast belongs to a different control, so pass it through
  wire logic selBypass = (lookupKind == UDF_KIND_MCAST) && lookupIpMcast;
  wire logic [NumPorts-1:0] selPorts = map_to_ports(selCtrl);
  // outside ip bypass, disabled or no selected port both drop
  wire logic selDrop = !selBypass && (!selCtrl.enable || selPorts == '0);

  // =====================================================
  // registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ucast_q <= '{enable: UDF_EN_RST, portMap: UDF_MAP_RST};
      mcast_q <= '{enable: UDF_EN_RST, portMap: UDF_MAP_RST};
      vlan_q  <= '{enable: UDF_EN_RST, portMap: UDF_MAP_RST};
    end else begin
      ucast_q <= ucast_d;
      mcast_q <= mcast_d;
      vlan_q  <= vlan_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      regRdData  <= regRdEn ? rdMux : 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fwdValid  <= 1'b0;
      fwdDrop   <= 1'b0;
      fwdPorts  <= '0;
      fwdBypass <= 1'b0;
    end else begin
      fwdValid  <= lookupValid;
      fwdDrop   <= lookupValid && selDrop;
      fwdPorts  <= (lookupValid && !selDrop && !selBypass) ? selPorts : '0;
      fwdBypass <= lookupValid && selBypass;
    end
  end

endmodule

// File: verif/udf_forward_ctrl_properties.sv
// checker for the forwarding control register bank
`timescale 1ns/1ps
module udf_forward_ctrl_properties import udf_pkg::*; #(parameter int NumPorts = 4) (
  // clock and reset
  input logic                clock,
  input logic                rst_n,
  // register access
  input logic                regWrEn,
  input logic                regRdEn,
  input logic [7:0]          regAddr,
  input logic [7:0]          regWrData,
  input logic [7:0]          regRdData,
  input logic                regRdValid,
  // lookup and decision
  input logic                lookupValid,
  input udf_kind_t           lookupKind,
  input logic                lookupIpMcast,
  input logic                fwdValid,
  input logic                fwdDrop,
  input logic [NumPorts-1:0] fwdPorts,
  input logic                fwdBypass
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rdA = regRdEn && regAddr == 8'h83;
  wire wrA = regWrEn && regAddr == 8'h83;
  chk_rd_pulse: assert property (regRdEn |=> regRdValid) else $error("no read valid");
  chk_rsvd_uc: assert property (rdA |=> regRdData[7:6] == 2'h2) else $error("rsvd 83");
  chk_rsvd_mc: assert property (regRdEn && regAddr == 8'h84 |=> regRdData[7:6] == 2'h1) else $error("rsvd 84");
  chk_rsvd_vl: assert property (regRdEn && regAddr == 8'h85 |=> regRdData[7:6] == 2'h0) else $error("rsvd 85");
  chk_unmap_zero: assert property (regRdEn && (regAddr < 8'h83 || regAddr > 8'h85) |=> regRdData == 8'h00) else $error("unmapped");
  // write then read back of the unicast register, fields only
  chk_wr_rd: assert property (wrA ##1 (rdA && !regWrEn) |=>
    (regRdData & 8'h3F) == ($past(regWrData, 2) & 8'h3F)) else $error("readback");
  chk_fwd_pulse: assert property (lookupValid |=> fwdValid) else $error("no decision");
  chk_ip_bypass: assert property (lookupValid && lookupKind == UDF_KIND_MCAST && lookupIpMcast |=>
    fwdBypass && !fwdDrop && fwdPorts == '0) else $error("ip mcast");
  chk_drop_empty: assert property (fwdDrop |-> fwdPorts == '0) else $error("drop with ports");
  cover property (fwdValid && fwdPorts == '1);
  cover property (fwdValid && fwdBypass);
  cover property (regRdValid && regRdData == 8'hBF);
  cover property (fwdValid && fwdDrop);
endmodule
bind udf_forward_ctrl udf_forward_ctrl_properties #(.NumPorts(NumPorts)) u_chk (
  .clock(clock), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .lookupValid(lookupValid),
  .lookupKind(lookupKind), .lookupIpMcast(lookupIpMcast), .fwdValid(fwdValid), .fwdDrop(fwdDrop),
  .fwdPorts(fwdPorts), .fwdBypass(fwdBypass)
);

// File: verif/udf_forward_ctrl_tb_top.sv
// self-checking bench for the forwarding control register bank
`timescale 1ns/1ps
module udf_forward_ctrl_tb_top import udf_pkg::*;;
  logic       clock = 1'h0, rst_n = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0, lookupValid = 1'h0, lookupIpMcast = 1'h0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  udf_kind_t  lookupKind = UDF_KIND_UCAST;
  logic       regRdValid, fwdValid, fwdDrop, fwdBypass;
  logic [3:0] fwdPorts;
  int         errors = 0, total_checks = 0, cyc = 0;
  udf_forward_ctrl #(.NumPorts(4)) dut (
    .clock(clock), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .lookupValid(lookupValid),
    .lookupKind(lookupKind), .lookupIpMcast(lookupIpMcast), .fwdValid(fwdValid), .fwdDrop(fwdDrop),
    .fwdPorts(fwdPorts), .fwdBypass(fwdBypass)
  );
  always #2.5 clock = ~clock;
  // whole run is about 40 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 800) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] s, e, input string nm);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  // strobes stay up until the next call sets them, so none is assigned twice in one step
  task automatic drive(input logic w, r, l);
    {regWrEn, regRdEn, lookupValid} = {w, r, l};
  endtask
  task automatic wr(input logic [7:0] a, d);
    drive(1'h1, 1'h0, 1'h0);
    {regAddr, regWrData} = {a, d};
    @(posedge clock) #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    drive(1'h0, 1'h1, 1'h0);
    regAddr = a;
    @(posedge clock) #1;
    chk(regRdData, e, "read");
    chk({7'h0, regRdValid}, 8'h01, "read valid");
  endtask
  // expected is {bypass, drop, ports}; valid is added as bit 6
  task automatic lk(input logic [1:0] k, input logic ip, input logic [7:0] e);
    drive(1'h0, 1'h0, 1'h1);
    lookupIpMcast = ip;
    lookupKind = udf_kind_t'(k);
    @(posedge clock) #1;
    chk({1'h0, fwdValid, fwdBypass, fwdDrop, fwdPorts}, e | 8'h40, "lookup");
  endtask
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    #1 rst_n = 1'h1;
    rd(8'h83, 8'h80);
    rd(8'h84, 8'h40);
    rd(8'h85, 8'h00);
    lk(2'h0, 1'h0, 8'h10);
    lk(2'h1, 1'h0, 8'h10);
    lk(2'h3, 1'h0, 8'h10);
    wr(8'h83, 8'hFF);
    rd(8'h83, 8'hBF);
    lk(2'h0, 1'h0, 8'h0F);
    lk(2'h0, 1'h1, 8'h0F);
    wr(8'h83, 8'h20);
    lk(2'h0, 1'h0, 8'h10);
    wr(8'h83, 8'h21);
    lk(2'h0, 1'h0, 8'h01);
    wr(8'h83, 8'h27);
    lk(2'h0, 1'h0, 8'h07);
    wr(8'h83, 8'h2F);
    lk(2'h0, 1'h0, 8'h07);
    wr(8'h84, 8'h3F);
    lk(2'h1, 1'h0, 8'h0F);
    lk(2'h1, 1'h1, 8'h20);
    wr(8'h84, 8'h23);
    lk(2'h1, 1'h0, 8'h03);
    wr(8'h85, 8'h27);
    lk(2'h3, 1'h0, 8'h07);
    wr(8'h85, 8'h3F);
    lk(2'h3, 1'h0, 8'h0F);
    lk(2'h2, 1'h0, 8'h0F);
    rd(8'h85, 8'h3F);
    wr(8'h85, 8'h1F);
    lk(2'h3, 1'h0, 8'h10);
    wr(8'h86, 8'hFF);
    rd(8'h86, 8'h00);
    // second reset in mid-run must restore defaults
    rst_n = 1'h0;
    @(posedge clock) #1 rst_n = 1'h1;
    rd(8'h83, 8'h80);
    lk(2'h1, 1'h0, 8'h10);
    report_and_stop();
  end
endmodule
